// ===== core/tsc_regs.svh
// Register addresses, field positions, reset values and timing figures
`ifndef TSC_REGS_SVH
`define TSC_REGS_SVH
`define TSC_CFG_INDEX       8'h88
`define TSC_CFG_ADDR        12'h220
`define TSC_STATUS_ADDR     12'h230
`define TSC_CFG_RESET       32'h0000_0000
`define TSC_PARITY_BIT      31
`define TSC_SEL_LSB         29
`define TSC_DIV_LSB         25
`define TSC_DTC_BIT         24
`define TSC_BEMF_LSB        21
`define TSC_HALT_LSB        18
`define TSC_BRKT_LSB        14
`define TSC_HDUTY_LSB       11
`define TSC_PDUTY_LSB       8
`define TSC_SURGE_BIT       7
`define TSC_CFG_USED_MASK   32'hffff_ff80
`define TSC_CLK_PERIOD_NS   10
`define TSC_MS_NS           1000000
`define TSC_MS_CYCLES       (`TSC_MS_NS / `TSC_CLK_PERIOD_NS)
`endif

// ===== core/tsc_pkg.sv
// Types shared by the tach and halt configuration block
package tsc_pkg;
	typedef enum logic [1:0] {
		TSC_TACH_ALWAYS      = 2'h0,
		TSC_TACH_CLOSED_ONLY = 2'h1,
		TSC_TACH_FIRST_TRY   = 2'h2,
		TSC_TACH_NONE        = 2'h3
	} tsc_tach_sel_t;

	typedef enum logic [2:0] {
		TSC_HALT_HIZ   = 3'h0,
		TSC_HALT_RECIR = 3'h1,
		TSC_HALT_LS    = 3'h2,
		TSC_HALT_HS    = 3'h3,
		TSC_HALT_SPIN  = 3'h4
	} tsc_halt_method_t;

	typedef enum logic [2:0] {
		TSC_ST_RUN   = 3'h0,
		TSC_ST_HIZ   = 3'h1,
		TSC_ST_RECIR = 3'h2,
		TSC_ST_WAIT  = 3'h3,
		TSC_ST_BRAKE = 3'h4,
		TSC_ST_DONE  = 3'h5
	} tsc_state_t;
endpackage

// ===== core/tsc_tach_if.sv
// Carrier between the main block and the tach pulse divider
`timescale 1ns/1ps
`default_nettype none
interface tsc_tach_if;
	logic       pulse_in;
	logic       enable;
	logic [3:0] divisor;
	logic       pulse_out;
	modport ctrl (output pulse_in, output enable, output divisor, input pulse_out);
	modport div  (input pulse_in, input enable, input divisor, output pulse_out);
endinterface
`default_nettype wire

// ===== core/tsc_tach_div.sv
// Divides the electrical-rate tach pulses down by a programmable factor
`timescale 1ns/1ps
`default_nettype none
module tsc_tach_div (
	input  wire logic pclk,
	input  wire logic presetn,
	tsc_tach_if.div   tif
);
	logic [3:0] count;

	// Counter is held clear while gated so each enabled span starts in phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count         <= 4'h0;
			tif.pulse_out <= 1'b0;
		end else if (!tif.enable) begin
			count         <= 4'h0;
			tif.pulse_out <= 1'b0;
		end else if (tif.pulse_in) begin
			if (count + 4'h1 >= tif.divisor) begin
				count         <= 4'h0;
				tif.pulse_out <= 1'b1;
			end else begin
				count         <= count + 4'h1;
				tif.pulse_out <= 1'b0;
			end
		end else begin
			tif.pulse_out <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ===== core/tsc_top.sv
// Tach output, power correction, halt method and brake configuration block
`timescale 1ns/1ps
`default_nettype none
`include "tsc_regs.svh"
// What this block does
// - Tach select: 0 both loops, 1 closed loop only, 2 first open-loop try only.
// - Tach divide codes 1 to 13 divide by the code; top code divides by 14.
// - Tach divide code 0 divides by three, like code 3.
// - Dead-time correction bit enables correction of power estimate in power modes.
// - Back-EMF threshold codes 0 to 5 give 1,2,5,10,20,30 mV symmetric.
// - Halt method: hi-z, recirculation, low-side, high-side braking, active spin-down.
// - Braking halt holds brake for 1 ms up to 15000 ms by code.
// - Halt duty threshold: immediate, or 50 down to 2.5 percent duty.
// - Brake-pin low-side braking has its own duty threshold, same code table.
module tsc_top #(
	parameter int MS_CYCLES = `TSC_MS_CYCLES
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        tach_raw_pulse,
	input  wire logic        closed_loop,
	input  wire logic        open_loop_first_try,
	input  wire logic        power_mode_active,
	input  wire logic        halt_request,
	input  wire logic        brake_pin,
	input  wire logic [9:0]  duty_now,
	output logic             tach_pulse_output,
	output logic             dead_time_correct,
	output logic      [15:0] tach_backemf_threshold_uv,
	output logic             tach_backemf_valid,
	output logic             gate_hiz,
	output logic             gate_recirculate,
	output logic             gate_low_brake,
	output logic             gate_high_brake,
	output logic             spin_down_active,
	output logic             halt_done,
	output logic             surge_guard_enable
);
	logic [31:0]           cfg;
	tsc_pkg::tsc_state_t   state;
	tsc_pkg::tsc_state_t   next_state;
	logic [16:0]           ms_count;
	logic [13:0]           brake_ms;
	logic                  access;
	logic                  cfg_hit;
	logic                  stat_hit;
	logic                  halt_thr_met;
	logic                  pin_thr_met;
	logic                  brake_over;
	tsc_pkg::tsc_tach_sel_t   tach_sel;
	tsc_pkg::tsc_halt_method_t halt_method;
	tsc_tach_if            tif ();

	assign tach_sel    = tsc_pkg::tsc_tach_sel_t'(cfg[`TSC_SEL_LSB +: 2]);
	assign halt_method = tsc_pkg::tsc_halt_method_t'(cfg[`TSC_HALT_LSB +: 3]);

	// Duty thresholds in tenths of a percent; zero means act at once
	function automatic logic [9:0] duty_thr(input logic [2:0] code);
		case (code)
			3'h1:    duty_thr = 10'h1f4;
			3'h2:    duty_thr = 10'h0fa;
			3'h3:    duty_thr = 10'h096;
			3'h4:    duty_thr = 10'h064;
			3'h5:    duty_thr = 10'h04b;
			3'h6:    duty_thr = 10'h032;
			3'h7:    duty_thr = 10'h019;
			default: duty_thr = 10'h000;
		endcase
	endfunction

	function automatic logic [13:0] brake_time_ms(input logic [3:0] code);
		case (code)
			4'h0:    brake_time_ms = 14'h0001;
			4'h1:    brake_time_ms = 14'h0002;
			4'h2:    brake_time_ms = 14'h0005;
			4'h3:    brake_time_ms = 14'h000a;
			4'h4:    brake_time_ms = 14'h000f;
			4'h5:    brake_time_ms = 14'h0019;
			4'h6:    brake_time_ms = 14'h0032;
			4'h7:    brake_time_ms = 14'h004b;
			4'h8:    brake_time_ms = 14'h0064;
			4'h9:    brake_time_ms = 14'h00fa;
			4'ha:    brake_time_ms = 14'h01f4;
			4'hb:    brake_time_ms = 14'h03e8;
			4'hc:    brake_time_ms = 14'h09c4;
			4'hd:    brake_time_ms = 14'h1388;
			4'he:    brake_time_ms = 14'h2710;
			default: brake_time_ms = 14'h3a98;
		endcase
	endfunction

	// APB slave: one wait state, answer registered on the second access cycle
	assign access   = psel && penable && !pready;
	assign cfg_hit  = (paddr == `TSC_CFG_ADDR);
	assign stat_hit = (paddr == `TSC_STATUS_ADDR);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= access;
			pslverr <= access && !(cfg_hit || (stat_hit && !pwrite));
			if (access && !pwrite && cfg_hit)
				prdata <= cfg;
			else if (access && !pwrite && stat_hit)
				prdata <= {28'h0000000, halt_done, 3'(state)};
			else
				prdata <= 32'h0000_0000;
		end
	end

	// Only the documented upper fields store; bits 6..0 belong elsewhere
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cfg <= `TSC_CFG_RESET;
		else if (psel && penable && pready && pwrite && cfg_hit)
			cfg <= pwdata & `TSC_CFG_USED_MASK;
	end

	// Tach gating and division
	always_comb begin
		tif.pulse_in = tach_raw_pulse;
		case (tach_sel)
			tsc_pkg::TSC_TACH_ALWAYS:      tif.enable = 1'b1;
			tsc_pkg::TSC_TACH_CLOSED_ONLY: tif.enable = closed_loop;
			tsc_pkg::TSC_TACH_FIRST_TRY:   tif.enable = !closed_loop && open_loop_first_try;
			default:                       tif.enable = 1'b0;
		endcase
		if (cfg[`TSC_DIV_LSB +: 4] == 4'h0)
			tif.divisor = 4'h3;
		else if (cfg[`TSC_DIV_LSB +: 4] >= 4'he)
			tif.divisor = 4'he;
		else
			tif.divisor = cfg[`TSC_DIV_LSB +: 4];
	end

	tsc_tach_div u_div (
		.pclk    (pclk),
		.presetn (presetn),
		.tif     (tif)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tach_pulse_output         <= 1'b0;
			dead_time_correct         <= 1'b0;
			surge_guard_enable        <= 1'b0;
			tach_backemf_threshold_uv <= 16'h0000;
			tach_backemf_valid        <= 1'b0;
		end else begin
			tach_pulse_output  <= tif.pulse_out;
			dead_time_correct  <= cfg[`TSC_DTC_BIT] && power_mode_active;
			surge_guard_enable <= cfg[`TSC_SURGE_BIT];
			tach_backemf_valid <= (cfg[`TSC_BEMF_LSB +: 3] <= 3'h5);
			case (cfg[`TSC_BEMF_LSB +: 3])
				3'h0:    tach_backemf_threshold_uv <= 16'h03e8;
				3'h1:    tach_backemf_threshold_uv <= 16'h07d0;
				3'h2:    tach_backemf_threshold_uv <= 16'h1388;
				3'h3:    tach_backemf_threshold_uv <= 16'h2710;
				3'h4:    tach_backemf_threshold_uv <= 16'h4e20;
				3'h5:    tach_backemf_threshold_uv <= 16'h7530;
				default: tach_backemf_threshold_uv <= 16'h0000;
			endcase
		end
	end

	// Halt sequencing
	assign halt_thr_met = (duty_thr(cfg[`TSC_HDUTY_LSB +: 3]) == 10'h000)
		|| (duty_now <= duty_thr(cfg[`TSC_HDUTY_LSB +: 3]));
	assign pin_thr_met = (duty_thr(cfg[`TSC_PDUTY_LSB +: 3]) == 10'h000)
		|| (duty_now <= duty_thr(cfg[`TSC_PDUTY_LSB +: 3]));
	// Ends on the last tick of the final millisecond so the brake lasts exactly the set time
	assign brake_over = (ms_count == 17'(MS_CYCLES - 1))
		&& (brake_ms + 14'h0001 >= brake_time_ms(cfg[`TSC_BRKT_LSB +: 4]));

	always_comb begin
		next_state = state;
		case (state)
			tsc_pkg::TSC_ST_RUN: begin
				if (halt_request) begin
					case (halt_method)
						tsc_pkg::TSC_HALT_RECIR: next_state = tsc_pkg::TSC_ST_RECIR;
						tsc_pkg::TSC_HALT_LS,
						tsc_pkg::TSC_HALT_HS,
						tsc_pkg::TSC_HALT_SPIN:  next_state = tsc_pkg::TSC_ST_WAIT;
						default:                 next_state = tsc_pkg::TSC_ST_HIZ;
					endcase
				end
			end
			tsc_pkg::TSC_ST_WAIT: begin
				if (halt_thr_met) begin
					if (halt_method == tsc_pkg::TSC_HALT_SPIN)
						next_state = tsc_pkg::TSC_ST_DONE;
					else
						next_state = tsc_pkg::TSC_ST_BRAKE;
				end
			end
			tsc_pkg::TSC_ST_BRAKE: begin
				if (brake_over)
					next_state = tsc_pkg::TSC_ST_DONE;
			end
			tsc_pkg::TSC_ST_HIZ,
			tsc_pkg::TSC_ST_RECIR: next_state = tsc_pkg::TSC_ST_DONE;
			tsc_pkg::TSC_ST_DONE:  next_state = tsc_pkg::TSC_ST_DONE;
			default:               next_state = tsc_pkg::TSC_ST_RUN;
		endcase
		// Dropping the request resumes the run from any halt stage
		if (!halt_request)
			next_state = tsc_pkg::TSC_ST_RUN;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			state <= tsc_pkg::TSC_ST_RUN;
		else
			state <= next_state;
	end

	// Millisecond tick shared by the brake timer; restarts on brake entry
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ms_count <= 17'h00000;
			brake_ms <= 14'h0000;
		end else if (state != tsc_pkg::TSC_ST_BRAKE) begin
			ms_count <= 17'h00000;
			brake_ms <= 14'h0000;
		end else if (ms_count == 17'(MS_CYCLES - 1)) begin
			ms_count <= 17'h00000;
			brake_ms <= brake_ms + 14'h0001;
		end else begin
			ms_count <= ms_count + 17'h00001;
		end
	end

	// The recirculation stage keeps its drive after completion until the run resumes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gate_hiz         <= 1'b0;
			gate_recirculate <= 1'b0;
			gate_low_brake   <= 1'b0;
			gate_high_brake  <= 1'b0;
			spin_down_active <= 1'b0;
			halt_done        <= 1'b0;
		end else begin
			gate_recirculate <= halt_request && (halt_method == tsc_pkg::TSC_HALT_RECIR)
				&& (next_state == tsc_pkg::TSC_ST_RECIR || next_state == tsc_pkg::TSC_ST_DONE);
			gate_hiz         <= (next_state == tsc_pkg::TSC_ST_HIZ)
				|| (next_state == tsc_pkg::TSC_ST_DONE
				&& halt_method != tsc_pkg::TSC_HALT_RECIR);
			// Brake pin braking works only outside a halt, low side only
			gate_low_brake   <= (next_state == tsc_pkg::TSC_ST_BRAKE
				&& halt_method == tsc_pkg::TSC_HALT_LS)
				|| (brake_pin && pin_thr_met && next_state == tsc_pkg::TSC_ST_RUN);
			gate_high_brake  <= next_state == tsc_pkg::TSC_ST_BRAKE
				&& halt_method == tsc_pkg::TSC_HALT_HS;
			spin_down_active <= next_state == tsc_pkg::TSC_ST_WAIT;
			halt_done        <= next_state == tsc_pkg::TSC_ST_DONE;
		end
	end
endmodule
`default_nettype wire

// ===== tb/tsc_top_props.sv
// Checker for the tach and halt configuration block ports
`timescale 1ns/1ps
`default_nettype none
`include "tsc_regs.svh"
module tsc_top_props (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        tach_raw_pulse,
	input wire logic        power_mode_active,
	input wire logic        tach_pulse_output,
	input wire logic        dead_time_correct,
	input wire logic [15:0] tach_backemf_threshold_uv,
	input wire logic        tach_backemf_valid,
	input wire logic        gate_hiz,
	input wire logic        gate_recirculate,
	input wire logic        gate_low_brake,
	input wire logic        gate_high_brake,
	input wire logic        surge_guard_enable
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence access_wait;
		psel && penable && !pready;
	endsequence
	sequence cfg_write;
		psel && penable && pready && pwrite && paddr == `TSC_CFG_ADDR && !pslverr;
	endsequence
	wait_state_a: assert property (access_wait |=> pready)
		else $error("no ready after one wait state");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready held too long");
	ready_qual_a: assert property (pready |-> psel && penable)
		else $error("ready outside access");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("error without ready");
	read_idle_a: assert property (!pready |-> prdata == 32'h0000_0000)
		else $error("read data outside access");
	surge_follow_a: assert property (cfg_write |=> ##1 surge_guard_enable == $past(pwdata[7], 2))
		else $error("surge enable does not follow write");
	dtc_mode_a: assert property (dead_time_correct |-> $past(power_mode_active))
		else $error("correction outside power mode");
	tach_cause_a: assert property (tach_pulse_output |-> $past(tach_raw_pulse, 2))
		else $error("tach output without raw pulse");
	bemf_valid_a: assert property (tach_backemf_valid == (tach_backemf_threshold_uv != 16'h0000))
		else $error("threshold valid mismatch");
	gate_excl_a: assert property ($onehot0({gate_hiz, gate_recirculate, gate_low_brake, gate_high_brake}))
		else $error("two gate modes at once");
endmodule
bind tsc_top tsc_top_props tsc_top_props_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.pwdata, .prdata, .pready, .pslverr, .tach_raw_pulse, .power_mode_active, .tach_pulse_output,
	.dead_time_correct, .tach_backemf_threshold_uv, .tach_backemf_valid, .gate_hiz,
	.gate_recirculate, .gate_low_brake, .gate_high_brake, .surge_guard_enable);
`default_nettype wire

// ===== tb/tsc_motor_model.sv
// Motor side model: emits a burst of electrical tach events on request
`timescale 1ns/1ps
`default_nettype none
module tsc_motor_model (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       launch,
	input  wire logic [5:0] count,
	output logic            tach_raw_pulse,
	output logic            busy
);
	logic [5:0] left;
	logic       ph;
	// Pulses every other cycle, like a fast commutating motor
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			left <= 6'h00;
			ph <= 1'b0;
			tach_raw_pulse <= 1'b0;
		end else begin
			if (launch)
				left <= count;
			else if (ph && left != 6'h00)
				left <= left - 6'h01;
			ph <= !ph;
			tach_raw_pulse <= ph && left != 6'h00 && !launch;
		end
	end
	assign busy = left != 6'h00 || tach_raw_pulse;
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// Testbench for the tach and halt configuration block
`timescale 1ns/1ps
`default_nettype none
`include "tsc_regs.svh"
module tb_top;
	localparam int MS = 10;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, launch, busy;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic        tach_raw_pulse, closed_loop, open_loop_first_try, power_mode_active;
	logic        halt_request, brake_pin, tach_pulse_output, dead_time_correct, e;
	logic [9:0]  duty_now;
	logic [15:0] tach_backemf_threshold_uv;
	logic        tach_backemf_valid, gate_hiz, gate_recirculate, gate_low_brake;
	logic        gate_high_brake, spin_down_active, halt_done, surge_guard_enable;
	logic [5:0]  count;
	logic [4:0]  seen;
	int          err_total, compares, ntach, nbrk, t0, b0, n;
	int          uv_tab[8] = '{1000, 2000, 5000, 10000, 20000, 30000, 0, 0};
	int          div_tab[5] = '{0, 1, 2, 13, 15};
	tsc_top #(.MS_CYCLES(MS)) tsc_top_i (.*);
	tsc_motor_model tsc_motor_model_i (.*);
	initial begin
		pclk = 0;
		forever #5 pclk = !pclk;
	end
	// Sampled on the falling edge so counts never race the design's updates
	always @(negedge pclk) begin
		if (tach_pulse_output) ntach++;
		if (gate_low_brake || gate_high_brake) nbrk++;
		seen |= {spin_down_active, gate_high_brake, gate_low_brake, gate_recirculate, gate_hiz};
	end
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
		if (n >= 50) begin
			err_total++;
			complete_run;
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic pulses(input int k);
		t0 = ntach;
		count <= 6'(k);
		launch <= 1'b1;
		@(posedge pclk);
		launch <= 1'b0;
		@(posedge pclk);
		// Model stays busy until its last event has left the pin
		while (busy) @(posedge pclk);
		repeat (4) @(posedge pclk);
	endtask
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		#300000;
		err_total++;
		complete_run;
	end
	initial begin
		{psel, penable, pwrite, paddr, pwdata, launch, count} = '0;
		{closed_loop, open_loop_first_try, power_mode_active, halt_request, brake_pin} = '0;
		duty_now = 10'h000;
		presetn = 0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(0, `TSC_CFG_ADDR, 0); chk("cfg reset", 32'h0, r);
		apb(1, `TSC_CFG_ADDR, 32'hffff_ffff);
		apb(0, `TSC_CFG_ADDR, 0); chk("cfg readback", 32'hffff_ff80, r);
		apb(0, 12'h3f0, 0); chk("unmapped err", 1, e);
		apb(1, `TSC_STATUS_ADDR, 32'hffff_ffff); chk("status write err", 1, e);
		apb(0, `TSC_STATUS_ADDR, 0); chk("status idle", 32'h0, r);
		$display("register test done");
		apb(1, `TSC_CFG_ADDR, 32'h0100_0080);
		power_mode_active <= 1'b1;
		repeat (3) @(posedge pclk);
		chk("dead time on", 1, dead_time_correct);
		chk("surge on", 1, surge_guard_enable);
		power_mode_active <= 1'b0;
		apb(1, `TSC_CFG_ADDR, 0);
		repeat (3) @(posedge pclk);
		chk("dead time off", 0, dead_time_correct);
		chk("surge off", 0, surge_guard_enable);
		for (int c = 0; c < 8; c++) begin
			apb(1, `TSC_CFG_ADDR, c << 21);
			repeat (3) @(posedge pclk);
			chk("bemf uv", uv_tab[c], tach_backemf_threshold_uv);
			chk("bemf valid", c < 6, tach_backemf_valid);
		end
		$display("field test done");
		open_loop_first_try <= 1'b1;
		for (int s = 0; s < 4; s++) begin
			apb(1, `TSC_CFG_ADDR, (s << 29) | (1 << 25));
			pulses(4); chk("tach select", (s == 0 || s == 2) ? 4 : 0, ntach - t0);
		end
		open_loop_first_try <= 1'b0;
		closed_loop <= 1'b1;
		foreach (div_tab[i]) begin
			apb(1, `TSC_CFG_ADDR, (1 << 29) | (div_tab[i] << 25));
			n = div_tab[i] == 0 ? 3 : (div_tab[i] > 13 ? 14 : div_tab[i]);
			pulses(2 * n); chk("tach divide", 2, ntach - t0);
		end
		$display("tach test done");
		for (int m = 0; m < 5; m++) begin
			apb(1, `TSC_CFG_ADDR, (m << 18) | (1 << 11));
			duty_now <= 10'd600;
			seen = '0;
			b0 = nbrk;
			halt_request <= 1'b1;
			repeat (20) @(posedge pclk);
			chk("halt wait done", m < 2, halt_done);
			chk("spin down", m >= 2, spin_down_active);
			duty_now <= 10'd500;
			for (int k = 0; k < 300 && halt_done !== 1'b1; k++) @(posedge pclk);
			chk("halt done", 1, halt_done);
			chk("method gate", 1, seen[m]);
			chk("brake cycles", (m == 2 || m == 3) ? MS : 0, nbrk - b0);
			apb(0, `TSC_STATUS_ADDR, 0);
			chk("halt status", {28'h0000000, 1'b1, 3'(tsc_pkg::TSC_ST_DONE)}, r);
			halt_request <= 1'b0;
			repeat (5) @(posedge pclk);
		end
		$display("halt test done");
		apb(1, `TSC_CFG_ADDR, 2 << 8);
		duty_now <= 10'd300;
		brake_pin <= 1'b1;
		repeat (4) @(posedge pclk);
		chk("pin brake above", 0, gate_low_brake);
		duty_now <= 10'd250;
		repeat (3) @(posedge pclk);
		chk("pin brake at", 1, gate_low_brake);
		brake_pin <= 1'b0;
		$display("brake pin test done");
		complete_run;
	end
endmodule
`default_nettype wire
